/* dv/clrf_core_assertions.sv */
`timescale 1ns/100ps
// port-level checks of the regulator reference and feedback block
module clrf_core_chk (
    input wire        clk,
    input wire        rstn,
    input wire [7:0]  addr,
    input wire        rd,
    input wire [31:0] rdata,
    input wire        display_mode,
    input wire [15:0] volt_demand,
    input wire [15:0] volt_mains,
    input wire [15:0] volt_cmd,
    input wire [31:0] process_value,
    input wire [31:0] ref_value,
    input wire [32:0] reg_error,
    input wire        freq_up,
    input wire        freq_down,
    input wire        speed_loop,
    input wire        process_loop,
    input wire [5:0]  display_process_unit,
    input wire        unit_visible
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    reg  [15:0] vlim;
    wire [19:0] vsum = {4'h0, volt_mains} + {4'h0, volt_mains} * 20'd5 / 20'd100;
    // voltage ceiling from the mains level seen at each edge
    always @(posedge clk or negedge rstn) begin
        if (!rstn) vlim <= 16'hffff;
        else vlim <= (vsum > 20'h0ffff) ? 16'hffff : vsum[15:0];
    end
    sequence s_rd_unmapped; rd && addr > 8'h2c; endsequence
    sequence s_no_rd; !rd; endsequence
    a_read_unmapped: assert property (s_rd_unmapped |=> rdata == 32'h0)
        else $error("unmapped read gave nonzero data");
    a_rdata_idle: assert property (s_no_rd |=> rdata == 32'h0)
        else $error("read data outside its cycle");
    a_loop_exclusive: assert property (!(speed_loop && process_loop))
        else $error("both loops selected");
    a_speed_rpm: assert property (speed_loop |-> display_process_unit == 6'h03)
        else $error("speed loop unit not rpm");
    a_unit_range: assert property (display_process_unit <= 6'h28)
        else $error("unit code above range");
    a_unit_shown: assert property (unit_visible |-> $past(display_mode))
        else $error("unit shown outside display mode");
    a_err_diff: assert property (reg_error == {1'b0, ref_value} - {1'b0, process_value})
        else $error("regulator error not ref minus feedback");
    a_dir_zero: assert property (reg_error == 33'h0 |-> !freq_up && !freq_down)
        else $error("frequency moves with zero error");
    a_dir_one: assert property (!(freq_up && freq_down))
        else $error("frequency up and down together");
    a_volt_ceiling: assert property (volt_cmd <= vlim)
        else $error("voltage above overmodulation ceiling");
    a_volt_pass: assert property ($past(volt_demand) <= $past(volt_mains) |-> volt_cmd == $past(volt_demand))
        else $error("demand within mains not passed");
endmodule
bind clrf_core clrf_core_chk u_chk (.clk(clk), .rstn(rstn), .addr(addr), .rd(rd),
    .rdata(rdata), .display_mode(display_mode), .volt_demand(volt_demand),
    .volt_mains(volt_mains), .volt_cmd(volt_cmd), .process_value(process_value),
    .ref_value(ref_value), .reg_error(reg_error), .freq_up(freq_up),
    .freq_down(freq_down), .speed_loop(speed_loop), .process_loop(process_loop),
    .display_process_unit(display_process_unit), .unit_visible(unit_visible));

/* dv/clrf_xmtr.sv */
`timescale 1ns/100ps
// transmitter model: each terminal holds its fraction as a level
module clrf_xmtr (
    input  wire        clk,
    input  wire        ld,
    input  wire [2:0]  sel,
    input  wire [15:0] val,
    output reg  [15:0] fb_pulse = 16'h0,
    output reg  [15:0] fb_volt = 16'h0,
    output reg  [15:0] fb_curr = 16'h0,
    output reg  [15:0] ref_pulse = 16'h0,
    output reg  [15:0] ref_volt = 16'h0,
    output reg  [15:0] ref_curr = 16'h0
);
    // a new level is taken on the edge that sees ld
    always @(posedge clk) begin
        if (ld) begin
            case (sel)
                3'h0: fb_pulse <= val;
                3'h1: fb_volt <= val;
                3'h2: fb_curr <= val;
                3'h3: ref_pulse <= val;
                3'h4: ref_volt <= val;
                default: ref_curr <= val;
            endcase
        end
    end
endmodule

/* dv/tb_closed_loop_reference_feedback.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_closed_loop_reference_feedback;
    reg         clk = 0, rstn = 0, wr = 0, rd = 0, dm = 0, ld = 0, rd_seen = 0;
    reg  [7:0]  addr = 0;
    reg  [31:0] wdata = 0, me;
    reg  [2:0]  sel = 0;
    reg  [15:0] xv = 0, vd = 0, vm = 0, f;
    wire [15:0] fp, fv, fc, rp, rv, rc;
    wire [31:0] rdata;
    int         n_fail = 0, checked = 0, i;
    logic [31:0] exp_q[$];
    logic [63:0] fl = 0, fh = 1500000, rlo = 0, rhi = 1500000;
    always #25 clk = ~clk;
    clrf_xmtr XM (.clk(clk), .ld(ld), .sel(sel), .val(xv), .fb_pulse(fp),
        .fb_volt(fv), .fb_curr(fc), .ref_pulse(rp), .ref_volt(rv), .ref_curr(rc));
    clrf_core DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .fb_pulse_in(fp), .fb_volt_in(fv),
        .fb_curr_in(fc), .ref_pulse_in(rp), .ref_volt_in(rv), .ref_curr_in(rc),
        .display_mode(dm), .volt_demand(vd), .volt_mains(vm), .volt_cmd(),
        .process_value(), .ref_value(), .reg_error(), .freq_up(), .freq_down(),
        .speed_loop(), .process_loop(), .display_process_unit(),
        .unit_visible());
    // expected process value and resulting reference
    function automatic [31:0] pv(input [15:0] x);
        return fl + (((fh - fl) * x) >> 16);
    endfunction
    function automatic [31:0] rf(input [15:0] x);
        logic [63:0] lo, hi, v;
        lo = rlo < fl ? fl : (rlo > fh ? fh : rlo);
        hi = rhi > fh ? fh : rhi;
        if (hi < lo) hi = lo;
        v = lo + (((hi - lo) * x) >> 16);
        return v > fh ? fh : (v < fl ? fl : v);
    endfunction
    // one bus cycle, then an idle cycle
    task bus(input w, input [7:0] a, input [31:0] d);
        wr <= w; rd <= !w; addr <= a; wdata <= d;
        @(posedge clk); wr <= 0; rd <= 0;
        @(posedge clk);
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        repeat (2) @(posedge clk);
        exp_q.push_back(e);
        bus(0, a, 0);
    endtask
    task xm(input [2:0] s, input [15:0] v);
        ld <= 1; sel <= s; xv <= v;
        @(posedge clk); ld <= 0;
        @(posedge clk);
    endtask
    task final_report;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // read data compared in the cycle after the read strobe
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) if (rd_seen) begin
        me = exp_q.pop_front();
        `CHK(rdata, me)
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report;
    end
    initial begin
        f = 16'($urandom(67));
        repeat (20) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        rchk(8'h00, 32'h221);
        rchk(8'h10, 32'h16e360);
        rchk(8'h04, 32'h0);
        rchk(8'h2c, 32'hc);
        bus(1, 8'h1c, 32'h1000);
        bus(1, 8'h30, 32'hffff);
        rchk(8'h1c, 32'h1000);
        rchk(8'h30, 32'h0);
        bus(1, 8'h04, 32'h29);
        rchk(8'h04, 32'h0);
        bus(1, 8'h04, 32'h28);
        rchk(8'h04, 32'h28);
        bus(1, 8'h10, 32'h0600_0000);
        rchk(8'h10, 32'h05f5_e100);
        bus(1, 8'h10, 32'h16e360);
        // process loop, direction of the frequency change
        bus(1, 8'h00, 32'h2203);
        bus(1, 8'h00, 32'h2202);
        rchk(8'h00, 32'h2203);
        xm(1, 16'h4000);
        xm(4, 16'h8000);
        rchk(8'h24, pv(16'h4000));
        rchk(8'h2c, 32'ha1);
        bus(1, 8'h00, 32'h2213);
        rchk(8'h2c, 32'ha2);
        xm(4, 16'h2000);
        rchk(8'h2c, 32'ha1);
        bus(1, 8'h00, 32'h2203);
        rchk(8'h2c, 32'ha2);
        xm(4, 16'h4000);
        dm <= 1;
        for (i = 0; i < 5; i++) begin
            bus(1, 8'h08, i << 4);
            rchk(8'h2c, (i == 2 || i == 3) ? 32'h1a0 : 32'ha0);
        end
        dm <= 0;
        bus(1, 8'h08, 32'h2);
        rchk(8'h2c, 32'ha0);
        // two feedback terminals at once
        bus(1, 8'h00, 32'h2303);
        xm(0, 16'h3000);
        rchk(8'h24, pv(16'h7000));
        xm(0, 16'hc000);
        rchk(8'h24, pv(16'hffff));
        xm(0, 16'h0);
        for (i = 0; i < 4; i++) begin
            f = 16'($urandom);
            xm(1, f);
            rchk(8'h24, pv(f));
        end
        // reference span, clamping and summing
        bus(1, 8'h14, 32'd100000);
        rlo = 100000;
        bus(1, 8'h18, 32'h05f5_e100);
        rhi = 32'h05f5_e100;
        rchk(8'h28, rf(16'h4000));
        bus(1, 8'h0c, 32'd200000);
        fl = 200000;
        rchk(8'h28, rf(16'h4000));
        bus(1, 8'h00, 32'h1a203);
        bus(1, 8'h20, 32'h0800);
        xm(3, 16'h1000);
        rchk(8'h28, rf(16'h5800));
        xm(4, 16'hf000);
        rchk(8'h28, rf(16'hffff));
        bus(1, 8'h00, 32'h6403);
        xm(5, 16'h4000);
        xm(4, 16'h1000);
        rchk(8'h28, rf(16'h1000));
        // voltage demand against mains, overmodulation off then on
        for (i = 0; i < 8; i++) begin
            vd <= 16'($urandom);
            vm <= 16'($urandom);
            if (i == 4) bus(1, 8'h00, 32'h6423);
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        final_report;
    end
endmodule

/* logic/clrf_core.v */
`timescale 1ns/100ps
`include "clrf_defines.vh"
module clrf_core #(
    parameter FW = 16
) (
    input  wire          clk,
    input  wire          rstn,
    input  wire [7:0]    addr,
    input  wire [31:0]   wdata,
    input  wire          wr,
    input  wire          rd,
    output reg  [31:0]   rdata,
    input  wire [FW-1:0] fb_pulse_in,
    input  wire [FW-1:0] fb_volt_in,
    input  wire [FW-1:0] fb_curr_in,
    input  wire [FW-1:0] ref_pulse_in,
    input  wire [FW-1:0] ref_volt_in,
    input  wire [FW-1:0] ref_curr_in,
    input  wire          display_mode,
    input  wire [15:0]   volt_demand,
    input  wire [15:0]   volt_mains,
    output reg  [15:0]   volt_cmd,
    output reg  [31:0]   process_value,
    output reg  [31:0]   ref_value,
    output reg  [32:0]   reg_error,
    output reg           freq_up,
    output reg           freq_down,
    output reg           speed_loop,
    output reg           process_loop,
    output reg  [5:0]    display_process_unit,
    output reg           unit_visible
);
    localparam [FW+1:0] FRAC_MAX = {2'b00, {FW{1'b1}}};

    reg  [31:0]   ctrl;
    reg  [5:0]    unit_code;
    reg  [15:0]   disp_lines;
    reg  [31:0]   feedback_scale_low;
    reg  [31:0]   feedback_scale_high;
    reg  [31:0]   ref_low;
    reg  [31:0]   ref_high;
    reg  [FW-1:0] bus_ref;
    reg  [FW-1:0] preset_ref;

    wire [1:0]    cfg_code;
    wire          fb_curr_on;
    wire          rf_curr_ok;
    wire [FW+1:0] fb_sum;
    wire [FW+2:0] rf_sum;
    wire [FW-1:0] fb_frac;
    wire [FW-1:0] rf_frac;
    wire [31:0]   rl_eff;
    wire [31:0]   rh_eff;
    wire [31:0]   fb_scaled;
    wire [31:0]   rf_scaled;
    wire [31:0]   next_ref;
    wire [32:0]   next_err;
    wire [23:0]   mains_ext;
    wire [23:0]   volt_lim_w;
    wire [15:0]   volt_lim;
    wire          next_visible;
    wire [31:0]   hi_wr;

    assign cfg_code = ctrl[1:0];

    // feedback terminals enabled together are added
    assign fb_sum = (ctrl[`CLRF_B_FB_PULSE] ? {2'b00, fb_pulse_in}
                                            : {(FW+2){1'b0}})
                  + (ctrl[`CLRF_B_FB_VOLT]  ? {2'b00, fb_volt_in}
                                            : {(FW+2){1'b0}})
                  + (ctrl[`CLRF_B_FB_CURR]  ? {2'b00, fb_curr_in}
                                            : {(FW+2){1'b0}});
    // beyond full scale the feedback fraction sticks at all ones, one step below the high point
    assign fb_frac = (fb_sum > FRAC_MAX) ? {FW{1'b1}}
                                         : fb_sum[FW-1:0];

    // current feedback locks out the current reference terminal
    assign fb_curr_on = ctrl[`CLRF_B_FB_CURR];
    assign rf_curr_ok = ctrl[`CLRF_B_RF_CURR] & ~fb_curr_on;

    // every enabled reference joins the sum, the current reference only while current feedback is off
    assign rf_sum = (ctrl[`CLRF_B_RF_PULSE]  ? {3'b000, ref_pulse_in}
                                             : {(FW+3){1'b0}})
                  + (ctrl[`CLRF_B_RF_VOLT]   ? {3'b000, ref_volt_in}
                                             : {(FW+3){1'b0}})
                  + (rf_curr_ok              ? {3'b000, ref_curr_in}
                                             : {(FW+3){1'b0}})
                  + (ctrl[`CLRF_B_RF_PRESET] ? {3'b000, preset_ref}
                                             : {(FW+3){1'b0}})
                  + (ctrl[`CLRF_B_RF_BUS]    ? {3'b000, bus_ref}
                                             : {(FW+3){1'b0}});
    assign rf_frac = (rf_sum > {1'b0, FRAC_MAX}) ? {FW{1'b1}}
                                                 : rf_sum[FW-1:0];

    // reference span trimmed so it never leaves the feedback span
    assign rl_eff = (ref_low < feedback_scale_low) ? feedback_scale_low
                  : (ref_low > feedback_scale_high) ? feedback_scale_high
                  : ref_low;
    assign rh_eff = (ref_high > feedback_scale_high) ? feedback_scale_high
                  : (ref_high < rl_eff) ? rl_eff
                  : ref_high;

    // feedback into process value between the two scaling points
    clrf_scale #(
        .FW    (FW)
    ) u_fb_scale (
        .frac  (fb_frac),
        .low   (feedback_scale_low),
        .high  (feedback_scale_high),
        .value (fb_scaled)
    );

    // summed reference mapped linearly between the trimmed minimum and maximum
    clrf_scale #(
        .FW    (FW)
    ) u_rf_scale (
        .frac  (rf_frac),
        .low   (rl_eff),
        .high  (rh_eff),
        .value (rf_scaled)
    );

    // final clamp of the resulting reference into the feedback range
    assign next_ref = (rf_scaled < feedback_scale_low) ? feedback_scale_low
                    : (rf_scaled > feedback_scale_high) ? feedback_scale_high
                    : rf_scaled;

    // setpoint minus feedback, signed
    assign next_err = {1'b0, next_ref} - {1'b0, fb_scaled};

    // voltage ceiling: mains, or mains plus the margin
    assign mains_ext  = {8'h00, volt_mains};
    assign volt_lim_w = ctrl[`CLRF_B_OVERMOD]
                      ? mains_ext + (mains_ext * {16'h0000, `CLRF_OVERMOD_PCT})
                        / {16'h0000, `CLRF_FULL_PCT}
                      : mains_ext;
    assign volt_lim   = (volt_lim_w > 24'h00ffff) ? 16'hffff
                                                  : volt_lim_w[15:0];

    // any display line asking for a value with its unit
    assign next_visible = display_mode &
        ((disp_lines[3:0]   == `CLRF_DISP_REF_U) |
         (disp_lines[3:0]   == `CLRF_DISP_FB_U)  |
         (disp_lines[7:4]   == `CLRF_DISP_REF_U) |
         (disp_lines[7:4]   == `CLRF_DISP_FB_U)  |
         (disp_lines[11:8]  == `CLRF_DISP_REF_U) |
         (disp_lines[11:8]  == `CLRF_DISP_FB_U)  |
         (disp_lines[15:12] == `CLRF_DISP_REF_U) |
         (disp_lines[15:12] == `CLRF_DISP_FB_U));

    // high scaling point saturated at its limit
    assign hi_wr = (wdata > `CLRF_FB_LIMIT) ? `CLRF_FB_LIMIT : wdata;

    // register writes
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl                <= `CLRF_RST_CTRL;
            unit_code           <= `CLRF_UNIT_NONE;
            disp_lines          <= 16'h0000;
            feedback_scale_low  <= `CLRF_RST_FB_LOW;
            feedback_scale_high <= `CLRF_RST_FB_HIGH;
            ref_low             <= `CLRF_RST_REF_LOW;
            ref_high            <= `CLRF_RST_REF_HI;
            bus_ref             <= {FW{1'b0}};
            preset_ref          <= {FW{1'b0}};
        end else if (wr) begin
            case (addr)
                `CLRF_A_CTRL: begin
                    // only the two loop codes are accepted
                    if (wdata[1:0] == `CLRF_CFG_SPEED ||
                        wdata[1:0] == `CLRF_CFG_PROC) begin
                        ctrl <= {15'h0000, wdata[16:8], 2'b00,
                                 wdata[5:4], 2'b00, wdata[1:0]};
                    end else begin
                        ctrl <= {15'h0000, wdata[16:8], 2'b00,
                                 wdata[5:4], 2'b00, ctrl[1:0]};
                    end
                end
                `CLRF_A_UNIT: begin
                    // codes past the last unit are dropped
                    if (wdata[31:6] == 26'h0 &&
                        wdata[5:0] <= `CLRF_UNIT_MAX) begin
                        unit_code <= wdata[5:0];
                    end
                end
                `CLRF_A_DISP: begin
                    disp_lines <= wdata[15:0];
                end
                `CLRF_A_FB_LOW: begin
                    feedback_scale_low <= (wdata > feedback_scale_high)
                                        ? feedback_scale_high : wdata;
                end
                `CLRF_A_FB_HIGH: begin
                    feedback_scale_high <= (hi_wr < feedback_scale_low)
                                         ? feedback_scale_low : hi_wr;
                end
                `CLRF_A_REF_LOW: begin
                    ref_low <= wdata;
                end
                `CLRF_A_REF_HIGH: begin
                    ref_high <= wdata;
                end
                `CLRF_A_BUS_REF: begin
                    bus_ref <= wdata[FW-1:0];
                end
                `CLRF_A_PRESET: begin
                    preset_ref <= wdata[FW-1:0];
                end
                default: begin
                    ctrl <= ctrl;
                end
            endcase
        end
    end

    // regulator-facing outputs, one register stage
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            process_value        <= 32'h0000_0000;
            ref_value            <= 32'h0000_0000;
            reg_error            <= 33'h0_0000_0000;
            freq_up              <= 1'b0;
            freq_down            <= 1'b0;
            speed_loop           <= 1'b0;
            process_loop         <= 1'b0;
            display_process_unit <= `CLRF_UNIT_NONE;
            unit_visible         <= 1'b0;
            volt_cmd             <= 16'h0000;
        end else begin
            process_value <= fb_scaled;
            ref_value     <= next_ref;
            reg_error     <= next_err;
            speed_loop    <= (cfg_code == `CLRF_CFG_SPEED);
            process_loop  <= (cfg_code == `CLRF_CFG_PROC);
            // direction from the error sign, turned round when inverted
            if (next_err == 33'h0_0000_0000) begin
                freq_up   <= 1'b0;
                freq_down <= 1'b0;
            end else if (next_err[32] ^ ~ctrl[`CLRF_B_INVERT]) begin
                freq_up   <= 1'b1;
                freq_down <= 1'b0;
            end else begin
                freq_up   <= 1'b0;
                freq_down <= 1'b1;
            end
            // speed loop always in rpm
            display_process_unit <= (cfg_code == `CLRF_CFG_SPEED)
                                  ? `CLRF_UNIT_RPM : unit_code;
            unit_visible <= next_visible;
            volt_cmd <= (volt_demand > volt_lim) ? volt_lim
                                                 : volt_demand;
        end
    end

    // read port, data in the cycle after the strobe
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                `CLRF_A_CTRL:     rdata <= ctrl;
                `CLRF_A_UNIT:     rdata <= {26'h0, unit_code};
                `CLRF_A_DISP:     rdata <= {16'h0000, disp_lines};
                `CLRF_A_FB_LOW:   rdata <= feedback_scale_low;
                `CLRF_A_FB_HIGH:  rdata <= feedback_scale_high;
                `CLRF_A_REF_LOW:  rdata <= ref_low;
                `CLRF_A_REF_HIGH: rdata <= ref_high;
                `CLRF_A_BUS_REF:  rdata <= {{(32-FW){1'b0}}, bus_ref};
                `CLRF_A_PRESET:   rdata <= {{(32-FW){1'b0}}, preset_ref};
                `CLRF_A_FB_VAL:   rdata <= process_value;
                `CLRF_A_REF_VAL:  rdata <= ref_value;
                `CLRF_A_STATUS:   rdata <= {23'h0, unit_visible,
                                            display_process_unit,
                                            freq_down, freq_up};
                default:          rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule

/* logic/clrf_defines.vh */
`ifndef CLRF_DEFINES_VH
`define CLRF_DEFINES_VH
// register byte addresses
`define CLRF_A_CTRL      8'h00
`define CLRF_A_UNIT      8'h04
`define CLRF_A_DISP      8'h08
`define CLRF_A_FB_LOW    8'h0c
`define CLRF_A_FB_HIGH   8'h10
`define CLRF_A_REF_LOW   8'h14
`define CLRF_A_REF_HIGH  8'h18
`define CLRF_A_BUS_REF   8'h1c
`define CLRF_A_PRESET    8'h20
`define CLRF_A_FB_VAL    8'h24
`define CLRF_A_REF_VAL   8'h28
`define CLRF_A_STATUS    8'h2c
// control field positions
`define CLRF_B_INVERT    4
`define CLRF_B_OVERMOD   5
`define CLRF_B_FB_PULSE  8
`define CLRF_B_FB_VOLT   9
`define CLRF_B_FB_CURR   10
`define CLRF_B_RF_PULSE  12
`define CLRF_B_RF_VOLT   13
`define CLRF_B_RF_CURR   14
`define CLRF_B_RF_PRESET 15
`define CLRF_B_RF_BUS    16
// configuration codes
`define CLRF_CFG_SPEED   2'h1
`define CLRF_CFG_PROC    2'h3
// units and display codes
`define CLRF_UNIT_NONE   6'h00
`define CLRF_UNIT_RPM    6'h03
`define CLRF_UNIT_MAX    6'h28
`define CLRF_DISP_REF_U  4'h2
`define CLRF_DISP_FB_U   4'h3
// reset values, values in thousandths of a unit
`define CLRF_RST_CTRL    32'h0000_0221
`define CLRF_RST_FB_LOW  32'h0000_0000
`define CLRF_RST_FB_HIGH 32'h0016_e360
`define CLRF_FB_LIMIT    32'h05f5_e100
`define CLRF_RST_REF_LOW 32'h0000_0000
`define CLRF_RST_REF_HI  32'h0016_e360
// overmodulation margin in percent
`define CLRF_OVERMOD_PCT 8'h05
`define CLRF_FULL_PCT    8'h64
`endif

/* logic/clrf_scale.v */
`timescale 1ns/100ps
// linear map of a 16-bit fraction onto the span low..high
module clrf_scale #(
    parameter FW = 16
) (
    input  wire [FW-1:0] frac,
    input  wire [31:0]   low,
    input  wire [31:0]   high,
    output wire [31:0]   value
);
    wire [31:0]    span;
    wire [FW+31:0] prod;

    // an inverted span collapses onto the low point
    assign span  = (high > low) ? (high - low) : 32'h0000_0000;
    assign prod  = span * frac;
    assign value = low + prod[FW+31:FW];
endmodule
